// >>> common/sfir_pkg.sv
// Shared constants and types for the serial flash command core
package sfir_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 20;

  // Command codes
  localparam logic [7:0] OP_IDENT_READ = 8'h9F;
  localparam logic [7:0] OP_QUAD_IDENT_READ = 8'hAF;
  localparam logic [7:0] OP_MAKER_DEV_IDENT_READ = 8'h90;
  localparam logic [7:0] OP_LEGACY_SIG_READ = 8'hAB;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_MODIFY_PERMIT_SET = 8'h06;
  localparam logic [7:0] OP_MODIFY_PERMIT_CLEAR = 8'h04;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SMALL_REGION_CLEAR = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_CLEAR = 8'h52;
  localparam logic [7:0] OP_BLOCK_CLEAR = 8'hD8;
  localparam logic [7:0] OP_CHIP_CLEAR_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_CLEAR_B = 8'h60;
  localparam logic [7:0] OP_QUAD_CMD_MODE_ON = 8'h35;
  localparam logic [7:0] OP_QUAD_CMD_MODE_OFF = 8'hF5;

  // Identification bytes (values are arbitrary)
  localparam logic [7:0] ID_MAKER = 8'h5A;
  localparam logic [7:0] ID_MEM_TYPE = 8'h61;
  localparam logic [7:0] ID_DENSITY = 8'h14;
  localparam logic [7:0] ID_DEVICE = 8'h14;
  localparam logic [7:0] ID_FILL = 8'hFF;

  // Status byte layout and reset values
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_QE = 6;
  localparam int ST_RSVD = 7;
  localparam logic [3:0] BP_RESET = 4'h0;
  localparam logic ST_QE_VALUE = 1'b1;

  // Frame geometry
  localparam logic [1:0] ADDR_BYTES_LAST = 2'd2;
  localparam logic [1:0] DUMMY_LAST_SINGLE = 2'd0;
  localparam logic [1:0] DUMMY_LAST_QUAD = 2'd1;
  localparam logic [1:0] STORE_BYTES_MAX = 2'd2;
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;
  localparam logic [3:0] STEP_SINGLE = 4'd1;
  localparam logic [3:0] STEP_QUAD = 4'd4;

  // Self-timed cycle durations and cycle counts
  localparam int STATUS_WRITE_TIME_NS = 40000;
  localparam int PROG_TIME_NS = 8000;
  localparam int ERASE_TIME_NS = 60000;
  localparam int BUSY_CNT_W = 13;
  localparam logic [BUSY_CNT_W-1:0] STATUS_WRITE_CYC =
    BUSY_CNT_W'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BUSY_CNT_W-1:0] PROG_CYC =
    BUSY_CNT_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BUSY_CNT_W-1:0] ERASE_CYC =
    BUSY_CNT_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Frame phases
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT, PH_IN, PH_IGNORE} sfir_phase_e;

  // Kind of self-timed cycle running
  typedef enum logic [2:0] {OPK_NONE, OPK_STORE, OPK_PROG, OPK_ERASE, OPK_CHIP} sfir_op_e;

  // Driven side of the four data lines
  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe;
  } sfir_pad_s;

endpackage

// >>> core/sfir_flash_core.sv
// Serial flash command core: identification, status and array reads
`timescale 1ns/1ps

// What this block does
// - After quad ident command, drive ident data on falling edges, MSB first.
// - Quad ident returns maker, memory type, density bytes until select rises.
// - Maker/device read: address 00h gives maker first, 01h gives device first.
// - Status fetch is accepted anytime, even during a self-timed cycle.
// - Status fetch command takes 8 clocks single-line or 2 clocks four-line.
// - Status byte: busy bit0, permit bit1, protect bits2-5, quad bit6, bit7 reserved.
// - Busy flag reads 1 during program, erase or status write, else 0.
// - Program and erase ignored unless permit latch set; only permit-set sets it.
// - Permit latch clears automatically when program or erase ends.
// - Program or erase at protected address is discarded and clears permit latch.
// - Protect bits reset to zero, changed only by status store, guard writes.
// - Chip erase runs only when all four protect bits are zero.
// - Quad-enable bit always reads 1 and cannot change.
// - Status store executes only if select rises after exactly 8 or 16 bits.
// - Status write starts at select rise; busy set, then busy and permit clear.
// - Normal read takes 3 address bytes, then streams data until select rises.
// - Array reads increment address per byte, wrapping to zero past the top.
// - Single-line fast read has 3 address bytes and one dummy byte.
// - Four-line fast read: 2-clock command, 24-bit address, 4 dummy clocks.
// - Fast read rejected during a self-timed cycle, cycle unaffected.
// - Single-line ident returns maker then two device bytes, ends at select rise.
// - Permit-clear command clears permit latch on completion.
module sfir_flash_core #(
  parameter int MEM_DEPTH = 4096,
  parameter int ADDR_W = 12,
  parameter int PROT_UNIT = 256,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_in,
  output sfir_pkg::sfir_pad_s io_pad
);
  import sfir_pkg::*;

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [ADDR_W-1:0] ADDR_MAX = ADDR_W'(MEM_DEPTH - 1);

  logic cs_meta_reg, cs_s_reg, cs_d_reg;
  logic sclk_meta_reg, sclk_s_reg, sclk_d_reg;
  logic [3:0] io_meta_reg, io_s_reg;
  logic selected, sclk_rise, sclk_fall, cs_rise;
  logic [7:0] in_sr_reg, in_byte, store_byte_reg;
  logic [3:0] in_bits_reg, in_bits_inc;
  logic byte_done;
  sfir_phase_e phase_reg;
  logic [7:0] cmd_reg;
  logic cmd_ok_reg;
  logic [1:0] cnt_reg;
  logic quad_reg, wel_reg, busy_reg;
  logic [3:0] bp_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  sfir_op_e op_kind_reg;
  logic [7:0] status_byte;
  logic [23:0] addr_reg;
  logic [1:0] idx_reg;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] prod_byte;
  logic push, pop, prog_ok;
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [PTR_W:0] fifo_cnt_reg;
  logic [7:0] out_sr_reg, out_byte;
  logic [3:0] out_left_reg, out_step;
  sfir_pad_s pad_reg;

  // Wraps a ring index
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Next array address, rolling over to zero past the top
  function automatic logic [23:0] next_addr(input logic [23:0] a);
    next_addr = (a[ADDR_W-1:0] == ADDR_MAX) ? 24'h00_0000 : 24'(a[ADDR_W-1:0] + 1'b1);
  endfunction

  // Top-of-array region guarded by the protect level
  function automatic logic is_protected(input logic [23:0] a, input logic [3:0] lvl);
    int span;
    span = 0;
    if (lvl != 4'h0) begin
      span = PROT_UNIT << (int'(lvl) - 1);
    end
    is_protected = (lvl != 4'h0) &&
      ((span >= MEM_DEPTH) || (int'(a[ADDR_W-1:0]) >= MEM_DEPTH - span));
  endfunction

  // Pin synchronisers and edge history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_meta_reg <= 1'b1;
      cs_s_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_s_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      io_meta_reg <= 4'h0;
      io_s_reg <= 4'h0;
    end else begin
      cs_meta_reg <= cs_n_pin;
      cs_s_reg <= cs_meta_reg;
      cs_d_reg <= cs_s_reg;
      sclk_meta_reg <= sclk_pin;
      sclk_s_reg <= sclk_meta_reg;
      sclk_d_reg <= sclk_s_reg;
      io_meta_reg <= io_in;
      io_s_reg <= io_meta_reg;
    end
  end

  // Edge events of the serial clock and select
  assign selected = !cs_s_reg;
  assign sclk_rise = selected && sclk_s_reg && !sclk_d_reg;
  assign sclk_fall = selected && !sclk_s_reg && sclk_d_reg;
  assign cs_rise = cs_s_reg && !cs_d_reg;

  // Input byte assembly; upper lines ignored in single-line mode
  assign in_byte = quad_reg ? {in_sr_reg[3:0], io_s_reg} : {in_sr_reg[6:0], io_s_reg[0]};
  assign in_bits_inc = in_bits_reg + (quad_reg ? STEP_QUAD : STEP_SINGLE);
  assign byte_done = sclk_rise && (in_bits_inc == BITS_PER_BYTE);

  // Input shifter, sampled on rising serial-clock edges
  always_ff @(posedge core_clk) begin
    if (rst || !selected) begin
      in_sr_reg <= 8'h00;
      in_bits_reg <= 4'h0;
    end else if (sclk_rise) begin
      in_sr_reg <= in_byte;
      in_bits_reg <= byte_done ? 4'h0 : in_bits_inc;
    end
  end

  // Frame phase sequencing
  always_ff @(posedge core_clk) begin
    if (rst || !selected) begin
      phase_reg <= PH_CMD;
      cnt_reg <= 2'd0;
      cmd_ok_reg <= rst ? 1'b0 : cmd_ok_reg;
    end else if (byte_done) begin
      unique case (phase_reg)
        PH_CMD: begin
          cmd_reg <= in_byte;
          cnt_reg <= 2'd0;
          cmd_ok_reg <= !(busy_reg && in_byte != OP_STATUS_FETCH);
          if (busy_reg && in_byte != OP_STATUS_FETCH) begin
            phase_reg <= PH_IGNORE;
          end else if (in_byte == OP_STATUS_FETCH || in_byte == OP_IDENT_READ ||
                       in_byte == OP_QUAD_IDENT_READ) begin
            phase_reg <= PH_OUT;
          end else if (in_byte == OP_ARRAY_READ || in_byte == OP_FAST_READ ||
                       in_byte == OP_MAKER_DEV_IDENT_READ || in_byte == OP_LEGACY_SIG_READ ||
                       in_byte == OP_PAGE_WRITE || in_byte == OP_SMALL_REGION_CLEAR ||
                       in_byte == OP_HALF_BLOCK_CLEAR || in_byte == OP_BLOCK_CLEAR) begin
            phase_reg <= PH_ADDR;
          end else if (in_byte == OP_STATUS_STORE) begin
            phase_reg <= PH_IN;
          end else begin
            phase_reg <= PH_IGNORE;
          end
        end
        PH_ADDR: begin
          cnt_reg <= (cnt_reg == ADDR_BYTES_LAST) ? 2'd0 : cnt_reg + 2'd1;
          if (cnt_reg == ADDR_BYTES_LAST) begin
            if (cmd_reg == OP_FAST_READ) begin
              phase_reg <= PH_DUMMY;
            end else if (cmd_reg == OP_PAGE_WRITE) begin
              phase_reg <= PH_IN;
            end else if (cmd_reg == OP_SMALL_REGION_CLEAR || cmd_reg == OP_HALF_BLOCK_CLEAR ||
                         cmd_reg == OP_BLOCK_CLEAR) begin
              phase_reg <= PH_IGNORE;
            end else begin
              phase_reg <= PH_OUT;
            end
          end
        end
        PH_DUMMY: begin
          cnt_reg <= cnt_reg + 2'd1;
          if (cnt_reg == (quad_reg ? DUMMY_LAST_QUAD : DUMMY_LAST_SINGLE)) begin
            phase_reg <= PH_OUT;
          end
        end
        PH_IN: begin
          if (cnt_reg == 2'd0) begin
            store_byte_reg <= in_byte;
          end
          if (cnt_reg != 2'd3) begin
            cnt_reg <= cnt_reg + 2'd1;
          end
        end
        PH_OUT, PH_IGNORE: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

  // Status byte as seen by the host
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY] = busy_reg;
    status_byte[ST_WEL] = wel_reg;
    status_byte[ST_BP_HI:ST_BP_LO] = bp_reg;
    status_byte[ST_QE] = ST_QE_VALUE;
  end

  // Self-timed cycles, permit latch, protect bits and mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wel_reg <= 1'b0;
      bp_reg <= BP_RESET;
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
      op_kind_reg <= OPK_NONE;
      quad_reg <= 1'b0;
    end else if (busy_reg) begin
      if (busy_cnt_reg == '0) begin
        busy_reg <= 1'b0;
        wel_reg <= 1'b0;
        op_kind_reg <= OPK_NONE;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end else if (cs_rise && cmd_ok_reg) begin
      case (cmd_reg)
        OP_MODIFY_PERMIT_SET: wel_reg <= 1'b1;
        OP_MODIFY_PERMIT_CLEAR: wel_reg <= 1'b0;
        OP_QUAD_CMD_MODE_ON: quad_reg <= 1'b1;
        OP_QUAD_CMD_MODE_OFF: quad_reg <= 1'b0;
        OP_STATUS_STORE: begin
          if (wel_reg && phase_reg == PH_IN && in_bits_reg == 4'h0 &&
              cnt_reg != 2'd0 && cnt_reg <= STORE_BYTES_MAX) begin
            bp_reg <= store_byte_reg[ST_BP_HI:ST_BP_LO];
            busy_reg <= 1'b1;
            busy_cnt_reg <= STATUS_WRITE_CYC - 1'b1;
            op_kind_reg <= OPK_STORE;
          end
        end
        OP_PAGE_WRITE: begin
          if (wel_reg && phase_reg == PH_IN) begin
            if (is_protected(addr_reg, bp_reg)) begin
              wel_reg <= 1'b0;
            end else begin
              busy_reg <= 1'b1;
              busy_cnt_reg <= PROG_CYC - 1'b1;
              op_kind_reg <= OPK_PROG;
            end
          end
        end
        OP_SMALL_REGION_CLEAR, OP_HALF_BLOCK_CLEAR, OP_BLOCK_CLEAR: begin
          if (wel_reg && phase_reg == PH_IGNORE) begin
            if (is_protected(addr_reg, bp_reg)) begin
              wel_reg <= 1'b0;
            end else begin
              busy_reg <= 1'b1;
              busy_cnt_reg <= ERASE_CYC - 1'b1;
              op_kind_reg <= OPK_ERASE;
            end
          end
        end
        OP_CHIP_CLEAR_A, OP_CHIP_CLEAR_B: begin
          if (wel_reg) begin
            if (bp_reg != 4'h0) begin
              wel_reg <= 1'b0;
            end else begin
              busy_reg <= 1'b1;
              busy_cnt_reg <= ERASE_CYC - 1'b1;
              op_kind_reg <= OPK_CHIP;
            end
          end
        end
        default: wel_reg <= wel_reg;
      endcase
    end
  end

  // Byte offered to the output buffer
  always_comb begin
    prod_byte = ID_FILL;
    if (cmd_reg == OP_STATUS_FETCH) begin
      prod_byte = status_byte;
    end else if (cmd_reg == OP_IDENT_READ || cmd_reg == OP_QUAD_IDENT_READ) begin
      prod_byte = (idx_reg == 2'd0) ? ID_MAKER :
                  (idx_reg == 2'd1) ? ID_MEM_TYPE : ID_DENSITY;
    end else if (cmd_reg == OP_MAKER_DEV_IDENT_READ) begin
      prod_byte = idx_reg[0] ? ID_DEVICE : ID_MAKER;
    end else if (cmd_reg == OP_LEGACY_SIG_READ) begin
      prod_byte = ID_DEVICE;
    end else if (cmd_reg == OP_ARRAY_READ || cmd_reg == OP_FAST_READ) begin
      prod_byte = mem[addr_reg[ADDR_W-1:0]];
    end
  end

  // Producer stalls while the buffer is full
  assign push = (phase_reg == PH_OUT) && (fifo_cnt_reg != (PTR_W+1)'(FIFO_DEPTH));
  assign prog_ok = cmd_ok_reg && wel_reg && !is_protected(addr_reg, bp_reg);

  // Address and identification sequence tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_reg <= 24'h00_0000;
      idx_reg <= 2'd0;
    end else if (phase_reg == PH_ADDR && byte_done) begin
      addr_reg <= {addr_reg[15:0], in_byte};
      idx_reg <= {1'b0, in_byte[0]};
    end else if (phase_reg == PH_IN && byte_done && cmd_reg == OP_PAGE_WRITE) begin
      addr_reg <= next_addr(addr_reg);
    end else if (push) begin
      if (cmd_reg == OP_ARRAY_READ || cmd_reg == OP_FAST_READ) begin
        addr_reg <= next_addr(addr_reg);
      end
      if (cmd_reg == OP_MAKER_DEV_IDENT_READ) begin
        idx_reg <= {1'b0, !idx_reg[0]};
      end else begin
        idx_reg <= (idx_reg == 2'd2) ? 2'd0 : idx_reg + 2'd1;
      end
    end else if (phase_reg == PH_CMD) begin
      idx_reg <= 2'd0;
    end
  end

  // Array write for accepted page writes
  always_ff @(posedge core_clk) begin
    if (phase_reg == PH_IN && byte_done && cmd_reg == OP_PAGE_WRITE && prog_ok) begin
      mem[addr_reg[ADDR_W-1:0]] <= in_byte;
    end
  end

  // Two-entry output buffer, flushed when select rises
  always_ff @(posedge core_clk) begin
    if (rst || !selected) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fifo_cnt_reg <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= prod_byte;
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      fifo_cnt_reg <= fifo_cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // Output shifter feeds from the buffer at each byte boundary
  assign pop = (phase_reg == PH_OUT) && sclk_fall && (out_left_reg == 4'h0) &&
               (fifo_cnt_reg != '0);
  assign out_byte = (out_left_reg != 4'h0) ? out_sr_reg :
                    (fifo_cnt_reg != '0) ? fifo_mem[rd_ptr_reg] : ID_FILL;
  assign out_step = quad_reg ? STEP_QUAD : STEP_SINGLE;

  // Data driven on falling serial-clock edges, MSB first
  always_ff @(posedge core_clk) begin
    if (rst || !selected) begin
      out_sr_reg <= 8'h00;
      out_left_reg <= 4'h0;
      pad_reg <= '0;
    end else if (phase_reg == PH_OUT && sclk_fall) begin
      out_left_reg <= ((out_left_reg == 4'h0) ? BITS_PER_BYTE : out_left_reg) - out_step;
      if (quad_reg) begin
        pad_reg.dat <= out_byte[7:4];
        pad_reg.oe <= 4'hF;
        out_sr_reg <= {out_byte[3:0], 4'h0};
      end else begin
        pad_reg.dat <= {2'b00, out_byte[7], 1'b0};
        pad_reg.oe <= 4'h2;
        out_sr_reg <= {out_byte[6:0], 1'b0};
      end
    end
  end

  assign io_pad = pad_reg;

  // Checks
  chk_quad_bit_fixed: assert property (@(posedge core_clk) disable iff (rst)
    status_byte[ST_QE] && !status_byte[ST_RSVD]) else $error("status fixed bits wrong");
  chk_busy_reject: assert property (@(posedge core_clk) disable iff (rst)
    (phase_reg == PH_CMD && byte_done && busy_reg && in_byte != OP_STATUS_FETCH)
    |=> phase_reg == PH_IGNORE) else $error("command taken while busy");
  chk_status_any: assert property (@(posedge core_clk) disable iff (rst)
    (phase_reg == PH_CMD && byte_done && in_byte == OP_STATUS_FETCH)
    |=> phase_reg == PH_OUT) else $error("status fetch not accepted");
  chk_store_start: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(busy_reg) && op_kind_reg == OPK_STORE) |-> $past(cs_rise) ##1 busy_reg[*8])
    else $error("status write cycle start wrong");
  chk_busy_end_wel: assert property (@(posedge core_clk) disable iff (rst)
    $fell(busy_reg) |-> !wel_reg && op_kind_reg == OPK_NONE) else $error("permit not cleared");
  chk_wel_set_src: assert property (@(posedge core_clk) disable iff (rst)
    $rose(wel_reg) |-> $past(cs_rise && cmd_reg == OP_MODIFY_PERMIT_SET))
    else $error("permit set without command");
  chk_chip_guard: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(busy_reg) && op_kind_reg == OPK_CHIP) |-> $past(bp_reg) == 4'h0)
    else $error("chip erase while protected");
  chk_cs_ends_read: assert property (@(posedge core_clk) disable iff (rst)
    cs_rise |=> phase_reg == PH_CMD && pad_reg.oe == 4'h0 && fifo_cnt_reg == '0)
    else $error("frame not ended at select rise");
  chk_first_drive: assert property (@(posedge core_clk) disable iff (rst)
    (phase_reg == PH_OUT && sclk_fall) |=> pad_reg.oe != 4'h0) else $error("no data driven");
  chk_addr_wrap: assert property (@(posedge core_clk) disable iff (rst)
    (push && cmd_reg == OP_ARRAY_READ && addr_reg[ADDR_W-1:0] == ADDR_MAX)
    |=> addr_reg == 24'h00_0000) else $error("address did not wrap");
  cov_status_busy: cover property (@(posedge core_clk) disable iff (rst)
    busy_reg && pop && cmd_reg == OP_STATUS_FETCH);
  cov_quad_ident: cover property (@(posedge core_clk) disable iff (rst)
    pop && quad_reg && cmd_reg == OP_QUAD_IDENT_READ);
  cov_fast_read: cover property (@(posedge core_clk) disable iff (rst)
    pop && cmd_reg == OP_FAST_READ);
  cov_store_run: cover property (@(posedge core_clk) disable iff (rst)
    $rose(busy_reg) && op_kind_reg == OPK_STORE);
endmodule

// >>> dv/sfir_host_model.sv
// Host controller model driving select, link clock and data lines
`timescale 1ns/1ps
module sfir_host_model (
  input wire logic core_clk,
  input wire sfir_pkg::sfir_pad_s io_pad,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic [3:0] io_in,
  output logic saw_oe
);
  import sfir_pkg::*;
  logic [3:0] hdat = 4'h0;
  logic [3:0] hoe = 4'h0;
  logic tog = 1'b0;
  // Idle: deselected, link clock parked low
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    saw_oe = 1'b0;
  end
  // Released lines flip every cycle so no stale level is read
  always @(posedge core_clk) tog <= ~tog;
  // Wire level from both parties' enables
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      io_in[k] = io_pad.oe[k] ? io_pad.dat[k] : (hoe[k] ? hdat[k] : tog);
    end
  end
  task automatic hw();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic open_f();
    hw();
    cs_n_pin = 1'b0;
    saw_oe = 1'b0;
    hw();
  endtask
  // Select high for well over one link period before the next frame
  task automatic close_f();
    hw();
    cs_n_pin = 1'b1;
    hoe = 4'h0;
    hw();
    hw();
  endtask
  // Clocks n beats MSB first: data set at the fall, read at the rise
  task automatic sh(input logic q, input int n, input logic [31:0] tx, input logic drv,
      output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      hoe = drv ? (q ? 4'hF : 4'h1) : 4'h0;
      hdat = q ? tx[4*i +: 4] : {3'b000, tx[i]};
      hw();
      rx = q ? {rx[27:0], io_in} : {rx[30:0], io_in[1]};
      saw_oe = saw_oe | (|io_pad.oe);
      sclk_pin = 1'b1;
      hw();
      sclk_pin = 1'b0;
    end
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the serial flash command core
`timescale 1ns/1ps
module testbench;
  import sfir_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n_pin;
  logic sclk_pin;
  logic saw_oe;
  logic [3:0] io_in;
  sfir_pad_s io_pad;
  logic [31:0] lfsr = 32'h0a41_63f0;
  logic [31:0] rx;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [3:0] bp;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  sfir_flash_core dut_u (.core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .io_in(io_in), .io_pad(io_pad));
  sfir_host_model host_u (.core_clk(core_clk), .io_pad(io_pad), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .io_in(io_in), .saw_oe(saw_oe));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Status byte as it should read
  function automatic logic [31:0] stat(input logic b, input logic w, input logic [3:0] p);
    return {24'h0, 1'b0, ST_QE_VALUE, p, w, b};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      results();
    end
  end
  // One frame: command, n beats sent, then k beats read
  task automatic frm(input logic q, input logic [7:0] op, input int n, input logic [31:0] v,
      input int k);
    host_u.open_f();
    host_u.sh(q, q ? 2 : 8, {24'h0, op}, 1'b1, rx);
    if (n > 0) host_u.sh(q, n, v, 1'b1, rx);
    if (k > 0) host_u.sh(q, k, 32'h0, 1'b0, rx);
    host_u.close_f();
  endtask
  task automatic sts(input logic [31:0] e);
    frm(1'b0, OP_STATUS_FETCH, 0, 0, 8);
    check(rx, e, "status");
  endtask
  // Polls the busy flag under a bound
  task automatic idle();
    for (int i = 0; i < 60; i++) begin
      frm(1'b0, OP_STATUS_FETCH, 0, 0, 8);
      if (rx[0] === 1'b0) break;
    end
  endtask
  task automatic put(input logic [23:0] a, input logic [7:0] d);
    frm(1'b0, OP_MODIFY_PERMIT_SET, 0, 0, 0);
    frm(1'b0, OP_PAGE_WRITE, 32, {a, d}, 0);
  endtask
  task automatic store(input int n, input logic [31:0] v);
    frm(1'b0, OP_MODIFY_PERMIT_SET, 0, 0, 0);
    frm(1'b0, OP_STATUS_STORE, n, v, 0);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    frm(1'b0, OP_STATUS_FETCH, 0, 0, 16);
    check(rx, stat(0, 0, BP_RESET) * 32'h101, "status repeat");
    frm(1'b0, OP_IDENT_READ, 0, 0, 24);
    check(rx, {8'h0, ID_MAKER, ID_MEM_TYPE, ID_DENSITY}, "ident");
    for (int a = 0; a < 2; a++) begin
      frm(1'b0, OP_MAKER_DEV_IDENT_READ, 24, 32'(a), 16);
      check(rx, a ? {16'h0, ID_DEVICE, ID_MAKER} : {16'h0, ID_MAKER, ID_DEVICE}, "mdid");
    end
    $display("done: reset and identification");
    d0 = lfsr[7:0];
    lfsr = lfsr_next(lfsr);
    d1 = lfsr[7:0];
    put(24'h00_0FFF, d0);
    sts(stat(1, 1, BP_RESET));
    idle();
    sts(stat(0, 0, BP_RESET));
    put(24'h00_0000, d1);
    idle();
    frm(1'b0, OP_ARRAY_READ, 24, 32'h00_0FFF, 16);
    check(rx, {16'h0, d0, d1}, "read wrap");
    frm(1'b0, OP_FAST_READ, 32, {24'h00_0FFF, 8'h00}, 16);
    check(rx, {16'h0, d0, d1}, "fast read");
    frm(1'b0, OP_QUAD_CMD_MODE_ON, 0, 0, 0);
    frm(1'b1, OP_QUAD_IDENT_READ, 0, 0, 6);
    check(rx, {8'h0, ID_MAKER, ID_MEM_TYPE, ID_DENSITY}, "quad ident");
    frm(1'b1, OP_FAST_READ, 6, 32'h00_0FFF, 8);
    check({16'h0, rx[15:0]}, {16'h0, d0, d1}, "quad fast");
    frm(1'b1, OP_STATUS_FETCH, 0, 0, 2);
    check(rx, stat(0, 0, BP_RESET), "quad status");
    frm(1'b1, OP_QUAD_CMD_MODE_OFF, 0, 0, 0);
    $display("done: program and reads");
    bp = lfsr[11:8] | 4'h1;
    store(8, {24'h0, 2'b00, bp, 2'b00});
    sts(stat(1, 1, bp));
    frm(1'b0, OP_FAST_READ, 32, 32'h0, 8);
    check({31'h0, saw_oe}, 32'h0, "fast read busy");
    sts(stat(1, 1, bp));
    idle();
    sts(stat(0, 0, bp));
    frm(1'b0, OP_MODIFY_PERMIT_SET, 0, 0, 0);
    frm(1'b0, OP_CHIP_CLEAR_A, 0, 0, 0);
    sts(stat(0, 0, bp));
    put(24'h00_0FFF, d1);
    sts(stat(0, 0, bp));
    frm(1'b0, OP_MODIFY_PERMIT_SET, 0, 0, 0);
    frm(1'b0, OP_SMALL_REGION_CLEAR, 24, 32'h00_0FFF, 0);
    sts(stat(0, 0, bp));
    store(12, 32'h0);
    sts(stat(0, 1, bp));
    frm(1'b0, OP_MODIFY_PERMIT_CLEAR, 0, 0, 0);
    sts(stat(0, 0, bp));
    store(16, {24'h0, lfsr[23:16]});
    idle();
    sts(stat(0, 0, BP_RESET));
    frm(1'b0, OP_PAGE_WRITE, 32, {24'h00_0010, d0}, 0);
    sts(stat(0, 0, BP_RESET));
    frm(1'b0, OP_MODIFY_PERMIT_SET, 0, 0, 0);
    frm(1'b0, OP_BLOCK_CLEAR, 24, 32'h00_0000, 0);
    sts(stat(1, 1, BP_RESET));
    idle();
    sts(stat(0, 0, BP_RESET));
    frm(1'b0, OP_LEGACY_SIG_READ, 24, 0, 16);
    check(rx, {16'h0, ID_DEVICE, ID_DEVICE}, "legacy sig");
    $display("done: status store and protection");
    results();
  end
endmodule
